// ===== hdl/fcs_sequencer.sv
// Flash command decoder and hardware sequence flag logic
`timescale 1ns/10ps
module fcs_sequencer
  import fcs_pkg::*;
(
  input  wire logic                   clock_i,
  input  wire logic                   reset_i,
  input  wire logic [31:0]            addr_i,
  input  wire logic [15:0]            wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  input  wire logic [1:0]             size_i,
  input  wire logic                   access_width_sel_i,
  input  wire logic [15:0]            array_rdata_i,
  input  wire logic                   op_done_i,
  input  wire logic                   time_limit_i,
  output logic      [15:0]            rdata_o,
  output logic                        ready_o,
  output logic                        prog_start_o,
  output logic      [31:0]            program_target_o,
  output logic      [15:0]            program_word_o,
  output logic                        erase_run_o,
  output logic                        erase_full_o,
  output logic      [NUM_SECTORS-1:0] erase_sector_pointer_o
);
  localparam int CNT_W = $clog2(WINDOW_CYC + 1);

  fcs_seq_t               seq_ff;
  fcs_seq_t               nxt_seq;
  fcs_op_t                op_ff;
  fcs_op_t                nxt_op;
  logic [CNT_W-1:0]       win_cnt_ff;
  logic                   toggle_ff;
  logic                   toggle2_ff;
  logic [15:0]            rdata_ff;
  logic                   prog_start_ff;
  logic [31:0]            target_ff;
  logic [15:0]            word_ff;
  logic [NUM_SECTORS-1:0] sect_ff;
  logic [NUM_SECTORS-1:0] nxt_sect;
  logic                   tlim_ff;
  logic                   third_ff;

  // Access qualification: flash range and programming mode
  wire       in_flash   = addr_i[31:16] == FLASH_BASE_HI;
  wire       prog_mode  = ~access_width_sel_i;
  wire       cmd_wr     = wr_i & in_flash & prog_mode;
  wire [7:0] code       = wdata_i[7:0];
  wire [15:0] low_addr  = addr_i[15:0];
  wire       at_a1      = low_addr == UNLOCK_ADDR1;
  wire       at_a2      = low_addr == UNLOCK_ADDR2;
  wire [1:0] sect_idx   = addr_i[SECT_LSB +: 2];
  wire [NUM_SECTORS-1:0] sect_hot = NUM_SECTORS'(1) << sect_idx;
  wire       busy       = op_ff != FCS_READ;
  wire       win_done   = (op_ff == FCS_WIN) && (win_cnt_ff == CNT_W'(WINDOW_CYC - 1));
  wire       susp_any   = (op_ff == FCS_SUSP) || (op_ff == FCS_SUSP_PROG);
  wire       in_erase_s = (sect_ff & sect_hot) != '0;
  wire       flag_read  = rd_i & in_flash & prog_mode & (size_i != SIZE_WORD);
  wire       prog_busy  = (op_ff == FCS_PROG) || (op_ff == FCS_SUSP_PROG);
  wire       do_reset   = cmd_wr && code == CODE_RESET && !prog_busy && op_ff != FCS_FULL
                          && op_ff != FCS_SECT && op_ff != FCS_WIN;
  wire       seq_hit    = (seq_ff == FCS_CYC1 && at_a1 && code == CODE_UNLOCK1) ||
                          (seq_ff == FCS_CYC2 && at_a2 && code == CODE_UNLOCK2) ||
                          (seq_ff == FCS_CYC3 && at_a1 &&
                           (code == CODE_PROGRAM || code == CODE_ERASE)) ||
                          (seq_ff == FCS_CYC4 &&
                           (third_ff || (at_a1 && code == CODE_UNLOCK1))) ||
                          (seq_ff == FCS_CYC5 && at_a2 && code == CODE_UNLOCK2) ||
                          (seq_ff == FCS_CYC6);
  logic prog_cmd;
  logic erase_cmd;
  logic third_prog;

  assign ready_o                = ~busy | susp_any & (op_ff != FCS_SUSP_PROG);
  assign rdata_o                = rdata_ff;
  assign prog_start_o           = prog_start_ff;
  assign program_target_o       = target_ff;
  assign program_word_o         = word_ff;
  assign erase_run_o            = (op_ff == FCS_FULL) || (op_ff == FCS_SECT);
  assign erase_full_o           = op_ff == FCS_FULL;
  assign erase_sector_pointer_o = sect_ff;

  // Unlock cycles and program commands may only be taken in read state or while suspended; erase only in read
  wire cmd_idle = (op_ff == FCS_READ) || (op_ff == FCS_SUSP);
  assign third_prog = (seq_ff == FCS_CYC3) && code == CODE_PROGRAM;
  assign prog_cmd  = cmd_wr && cmd_idle && seq_ff == FCS_CYC4 && third_ff
                     && !addr_i[0];
  assign erase_cmd = cmd_wr && op_ff == FCS_READ && seq_ff == FCS_CYC6 &&
                     ((at_a1 && code == CODE_FULL) || code == CODE_SECTOR);

  always_comb
  begin
    nxt_seq = FCS_CYC1;
    if (cmd_wr && cmd_idle && seq_hit && !do_reset)
    begin
      case (seq_ff)
        FCS_CYC1: nxt_seq = FCS_CYC2;
        FCS_CYC2: nxt_seq = FCS_CYC3;
        FCS_CYC3: nxt_seq = FCS_CYC4;
        FCS_CYC4: nxt_seq = (third_ff || op_ff == FCS_SUSP) ? FCS_CYC1 : FCS_CYC5;
        FCS_CYC5: nxt_seq = FCS_CYC6;
        default:  nxt_seq = FCS_CYC1;
      endcase
    end
    else if (!cmd_wr)
      nxt_seq = seq_ff;
    // Any mismatching command write falls back to the first cycle; writes outside flash or in read-only mode hold it
  end

  always_comb
  begin
    nxt_op   = op_ff;
    nxt_sect = sect_ff;
    case (op_ff)
      FCS_READ:
      begin
        if (prog_cmd)
          nxt_op = FCS_PROG;
        else if (erase_cmd && code == CODE_FULL)
        begin
          nxt_op   = FCS_FULL;
          nxt_sect = '1;
        end
        else if (erase_cmd)
        begin
          nxt_op   = FCS_WIN;
          nxt_sect = sect_hot;
        end
      end
      FCS_PROG, FCS_FULL:
      begin
        // Suspend ignored here; reset only after a time-limit overrun
        if (cmd_wr && code == CODE_RESET && tlim_ff)
          nxt_op = FCS_READ;
        else if (op_done_i)
          nxt_op = FCS_READ;
      end
      FCS_WIN:
      begin
        if (cmd_wr && code == CODE_SUSPEND)
          nxt_op = FCS_SUSP;
        else if (cmd_wr && code == CODE_SECTOR)
          nxt_sect = sect_ff | sect_hot;
        else if (win_done)
          nxt_op = FCS_SECT;
      end
      FCS_SECT:
      begin
        if (cmd_wr && code == CODE_SUSPEND)
          nxt_op = FCS_SUSP;
        else if (cmd_wr && code == CODE_RESET && tlim_ff)
          nxt_op = FCS_READ;
        else if (op_done_i)
        begin
          nxt_op   = FCS_READ;
          nxt_sect = '0;
        end
      end
      FCS_SUSP:
      begin
        if (prog_cmd && !in_erase_s)
          nxt_op = FCS_SUSP_PROG;
        else if (cmd_wr && seq_ff == FCS_CYC1 && code == CODE_SECTOR)
          nxt_op = FCS_SECT;
      end
      FCS_SUSP_PROG:
      begin
        if (op_done_i || (cmd_wr && code == CODE_RESET && tlim_ff))
          nxt_op = FCS_SUSP;
      end
      default: nxt_op = FCS_READ;
    endcase
    if (do_reset && op_ff == FCS_READ)
      nxt_op = FCS_READ;
  end

  // Flag word built from state; array data where the flags step aside
  logic [15:0] flags;
  always_comb
  begin
    flags = array_rdata_i;
    case (op_ff)
      FCS_PROG, FCS_SUSP_PROG:
      begin
        flags              = 16'h0000;
        flags[BIT_POLL]    = ~word_ff[7];
        flags[BIT_TOGGLE]  = toggle_ff;
        flags[BIT_TLIMIT]  = tlim_ff;
        flags[BIT_WINDOW]  = op_ff == FCS_SUSP_PROG;
      end
      FCS_FULL, FCS_WIN, FCS_SECT:
      begin
        flags              = 16'h0000;
        flags[BIT_TOGGLE]  = toggle_ff;
        flags[BIT_TLIMIT]  = tlim_ff;
        flags[BIT_WINDOW]  = op_ff != FCS_WIN;
        flags[BIT_TOGGLE2] = toggle2_ff;
      end
      FCS_SUSP:
      begin
        if (in_erase_s)
        begin
          flags              = 16'h0000;
          flags[BIT_WINDOW]  = 1'b1;
          flags[BIT_TOGGLE2] = toggle2_ff;
        end
      end
      default: flags = array_rdata_i;
    endcase
  end

  wire show_flags = flag_read && (busy || susp_any);
  wire tog_step   = show_flags && op_ff != FCS_SUSP;
  wire tog2_step  = show_flags && op_ff != FCS_PROG && op_ff != FCS_SUSP_PROG
                    && (op_ff != FCS_SUSP || in_erase_s);
  wire tlim_clr   = (nxt_op == FCS_READ) || (nxt_op == FCS_SUSP);

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      seq_ff   <= FCS_CYC1;
      op_ff    <= FCS_READ;
      sect_ff  <= '0;
      third_ff <= 1'b0;
    end
    else
    begin
      seq_ff  <= nxt_seq;
      op_ff   <= nxt_op;
      sect_ff <= nxt_sect;
      if (cmd_wr && seq_ff == FCS_CYC3)
        third_ff <= third_prog;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      win_cnt_ff <= '0;
      toggle_ff  <= 1'b0;
      toggle2_ff <= 1'b0;
      tlim_ff    <= 1'b0;
      rdata_ff   <= 16'h0000;
    end
    else
    begin
      // Window restarts on entry; extra sector codes do not extend it
      win_cnt_ff <= (op_ff == FCS_WIN) ? win_cnt_ff + CNT_W'(1) : '0;
      toggle_ff  <= toggle_ff ^ tog_step;
      toggle2_ff <= toggle2_ff ^ tog2_step;
      tlim_ff    <= tlim_clr ? 1'b0 : (tlim_ff | (busy & time_limit_i));
      if (rd_i)
        rdata_ff <= show_flags ? flags : array_rdata_i;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      prog_start_ff <= 1'b0;
      target_ff     <= 32'h0000_0000;
      word_ff       <= 16'h0000;
    end
    else
    begin
      prog_start_ff <= prog_cmd && (nxt_op != op_ff);
      if (prog_cmd && (nxt_op != op_ff))
      begin
        target_ff <= addr_i;
        word_ff   <= wdata_i;
      end
    end
  end

  a_prog_start: assert property (@(posedge clock_i) disable iff (reset_i)
    prog_start_o |-> op_ff == FCS_PROG || op_ff == FCS_SUSP_PROG)
    else $error("program start without program state");
  a_odd_reject: assert property (@(posedge clock_i) disable iff (reset_i)
    (cmd_wr && addr_i[0]) |=> !prog_start_o)
    else $error("odd program address accepted");
  a_rom_mode: assert property (@(posedge clock_i) disable iff (reset_i)
    (op_ff == FCS_READ && access_width_sel_i) |=> op_ff == FCS_READ)
    else $error("command taken in read-only mode");
  a_window_len: assert property (@(posedge clock_i) disable iff (reset_i)
    (op_ff == FCS_WIN && !cmd_wr && win_cnt_ff != CNT_W'(WINDOW_CYC - 1)) |=> op_ff == FCS_WIN)
    else $error("erase window ended early");
  a_suspend_ign: assert property (@(posedge clock_i) disable iff (reset_i)
    (op_ff == FCS_FULL) |=> op_ff != FCS_SUSP)
    else $error("suspend taken during full erase");
  a_poll_inv: assert property (@(posedge clock_i) disable iff (reset_i)
    (show_flags && op_ff == FCS_PROG) |=> rdata_o[BIT_POLL] == ~$past(word_ff[7]))
    else $error("poll bit not inverted");
  a_erase_flags: assert property (@(posedge clock_i) disable iff (reset_i)
    (show_flags && erase_run_o) |=> rdata_o[BIT_POLL] == 1'b0 && rdata_o[BIT_WINDOW])
    else $error("erase flags wrong");
  a_word_read: assert property (@(posedge clock_i) disable iff (reset_i)
    (rd_i && size_i == SIZE_WORD) |=> rdata_o == $past(array_rdata_i))
    else $error("flags returned on word read");
endmodule

// ===== pkg/fcs_pkg.sv
// Constants and types for the flash command sequencer
package fcs_pkg;
  localparam int          CLK_MHZ       = 50;
  localparam int          WINDOW_US     = 35;
  localparam int          WINDOW_CYC    = WINDOW_US * CLK_MHZ;
  localparam logic [15:0] UNLOCK_ADDR1  = 16'h0aa8;
  localparam logic [15:0] UNLOCK_ADDR2  = 16'h0554;
  localparam logic [7:0]  CODE_UNLOCK1  = 8'haa;
  localparam logic [7:0]  CODE_UNLOCK2  = 8'h55;
  localparam logic [7:0]  CODE_PROGRAM  = 8'ha0;
  localparam logic [7:0]  CODE_ERASE    = 8'h80;
  localparam logic [7:0]  CODE_FULL     = 8'h10;
  localparam logic [7:0]  CODE_SECTOR   = 8'h30;
  localparam logic [7:0]  CODE_RESET    = 8'hf0;
  localparam logic [7:0]  CODE_SUSPEND  = 8'hb0;
  localparam logic [15:0] FLASH_BASE_HI = 16'h0020;
  localparam int          NUM_SECTORS   = 4;
  localparam int          SECT_LSB      = 13;
  localparam int          BIT_POLL      = 7;
  localparam int          BIT_TOGGLE    = 6;
  localparam int          BIT_TLIMIT    = 5;
  localparam int          BIT_WINDOW    = 3;
  localparam int          BIT_TOGGLE2   = 2;
  localparam logic [1:0]  SIZE_BYTE     = 2'h0;
  localparam logic [1:0]  SIZE_HALF     = 2'h1;
  localparam logic [1:0]  SIZE_WORD     = 2'h2;

  typedef enum logic [2:0] {
    FCS_CYC1, FCS_CYC2, FCS_CYC3, FCS_CYC4, FCS_CYC5, FCS_CYC6
  } fcs_seq_t;

  typedef enum logic [2:0] {
    FCS_READ, FCS_PROG, FCS_FULL, FCS_WIN, FCS_SECT, FCS_SUSP, FCS_SUSP_PROG
  } fcs_op_t;
endpackage

// ===== test/fcs_flash_model.sv
// Flash array and embedded-algorithm timing model behind the sequencer
`timescale 1ns/10ps
module fcs_flash_model
(
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic [31:0] addr_i,
  input  wire logic        prog_start_i,
  input  wire logic        erase_run_i,
  input  wire logic        ready_i,
  input  wire logic        hang_i,
  input  wire logic [7:0]  delay_i,
  output logic      [15:0] array_rdata_o,
  output logic             op_done_o,
  output logic             time_limit_o
);
  logic       prog_pend_ff;
  logic [7:0] cnt_ff;
  wire        active = prog_pend_ff | erase_run_i;
  wire        hit    = active && (cnt_ff == delay_i);

  // Array content is a fixed scramble so every halfword address in the low 128 KiB reads differently
  assign array_rdata_o = addr_i[16:1] ^ 16'h5a3c;

  // Counter clears while suspended; a hung algorithm never finishes
  always_ff @(posedge clock_i or posedge reset_i)
    if (reset_i)
    begin
      prog_pend_ff <= 1'b0;
      cnt_ff       <= 8'h00;
      op_done_o    <= 1'b0;
      time_limit_o <= 1'b0;
    end
    else
    begin
      prog_pend_ff <= prog_start_i | (prog_pend_ff & ~ready_i);
      cnt_ff       <= (!active || op_done_o) ? 8'h00 : (hit ? cnt_ff : cnt_ff + 8'h01);
      op_done_o    <= hit & ~hang_i & ~op_done_o;
      time_limit_o <= ready_i ? 1'b0 : (time_limit_o | (hit & hang_i));
    end
endmodule

// ===== test/fcs_sequencer_test.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  begin cmp_count++; if ((got) !== (exp)) begin errors++; \
  $display("Error %s expected %h seen %h", nm, (exp), (got)); end end
module fcs_sequencer_test
  import fcs_pkg::*;
;
  localparam logic [31:0] FL = {FLASH_BASE_HI, 16'h0000};
  logic        clock_i;
  logic        reset_i;
  logic [31:0] addr;
  logic [15:0] wdata;
  logic        wr_s;
  logic        rd_s;
  logic [1:0]  size;
  logic        aws;
  logic        hang;
  logic [7:0]  delay;
  logic [15:0] rdata;
  logic [15:0] arr;
  logic [15:0] word;
  logic [31:0] target;
  logic [3:0]  ptr;
  logic        ready;
  logic        prog_start;
  logic        erase_run;
  logic        erase_full;
  logic        done;
  logic        tlim;
  logic [15:0] r1;
  logic [15:0] r2;
  int          errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          el;
  time         t0;

  fcs_sequencer u_fcs_sequencer (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .size_i(size), .access_width_sel_i(aws),
    .array_rdata_i(arr), .op_done_i(done), .time_limit_i(tlim), .rdata_o(rdata),
    .ready_o(ready), .prog_start_o(prog_start), .program_target_o(target),
    .program_word_o(word), .erase_run_o(erase_run), .erase_full_o(erase_full),
    .erase_sector_pointer_o(ptr));
  fcs_flash_model u_fcs_flash_model (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr),
    .prog_start_i(prog_start), .erase_run_i(erase_run), .ready_i(ready), .hang_i(hang),
    .delay_i(delay), .array_rdata_o(arr), .op_done_o(done), .time_limit_o(tlim));

  always #10 clock_i = ~clock_i;

  function automatic logic [15:0] arr_val(input logic [31:0] a);
    return a[16:1] ^ 16'h5a3c;
  endfunction

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Whole run is a few thousand cycles; the ceiling leaves ample margin
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      close_out();
    end
  end

  task automatic bus_wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock_i);
    wr_s <= 1'b0;
  endtask

  task automatic bus_rd(input logic [31:0] a, input logic [1:0] s, output logic [15:0] r);
    @(posedge clock_i);
    addr <= a;
    size <= s;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    #1;
    r = rdata;
  endtask

  // Upper data byte is junk on purpose, so only the low byte may decode
  task automatic unlock(input logic [7:0] c, input logic [31:0] a);
    bus_wr(FL | {16'h0, UNLOCK_ADDR1}, {8'hc3, CODE_UNLOCK1});
    bus_wr(FL | {16'h0, UNLOCK_ADDR2}, {8'h3c, CODE_UNLOCK2});
    bus_wr(a, {8'h9e, c});
  endtask

  task automatic prog(input logic [31:0] a, input logic [15:0] d);
    unlock(CODE_PROGRAM, FL | {16'h0, UNLOCK_ADDR1});
    bus_wr(a, d);
    #1;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic wait_ready(input int n);
    for (int i = 0; i < n && ready !== 1'b1; i++)
      tick(1);
    `CHK("ready", 1'b1, ready)
  endtask

  initial
  begin
    clock_i = 1'b0;
    reset_i = 1'b1;
    addr = FL;
    wdata = 16'h0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    size = SIZE_HALF;
    aws = 1'b1;
    hang = 1'b0;
    delay = 8'd40;
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
    prog(FL | 32'h0100, 16'h1234);
    `CHK("prog_start", 1'b0, prog_start)
    bus_rd(FL | 32'h0100, SIZE_WORD, r1);
    `CHK("word read", arr_val(FL | 32'h0100), r1)
    $display("Test read_only finished");
    @(posedge clock_i);
    aws <= 1'b0;
    prog(FL | 32'h0100, 16'ha581);
    `CHK("prog_start", 1'b1, prog_start)
    `CHK("target", FL | 32'h0100, target)
    `CHK("word", 16'ha581, word)
    `CHK("ready", 1'b0, ready)
    bus_rd(FL, SIZE_HALF, r1);
    bus_rd(FL | 32'h0200, SIZE_HALF, r1);
    bus_rd(FL | 32'h0200, SIZE_HALF, r2);
    `CHK("poll", 1'b0, r1[BIT_POLL])
    `CHK("toggle", ~r1[BIT_TOGGLE], r2[BIT_TOGGLE])
    bus_rd(FL | 32'h0200, SIZE_WORD, r1);
    `CHK("word flags", arr_val(FL | 32'h0200), r1)
    wait_ready(100);
    bus_rd(FL | 32'h0100, SIZE_HALF, r1);
    `CHK("array", arr_val(FL | 32'h0100), r1)
    prog(FL | 32'h0301, 16'h0011);
    `CHK("odd start", 1'b0, prog_start)
    prog(32'h0030_0100, 16'h0011);
    `CHK("range start", 1'b0, prog_start)
    bus_wr(FL | 32'h0101, 16'h0011);
    #1;
    `CHK("flush start", 1'b0, prog_start)
    bus_wr(FL | {16'h0, UNLOCK_ADDR1}, 16'h00aa);
    bus_wr(FL | {16'h0, UNLOCK_ADDR2}, 16'h0012);
    bus_wr(FL | {16'h0, UNLOCK_ADDR1}, 16'h00a0);
    bus_wr(FL | 32'h0100, 16'h0011);
    #1;
    `CHK("abort start", 1'b0, prog_start)
    prog(FL | 32'h0400, 16'h0011);
    `CHK("restart", 1'b1, prog_start)
    wait_ready(100);
    $display("Test program finished");
    delay = 8'd60;
    unlock(CODE_ERASE, FL | {16'h0, UNLOCK_ADDR1});
    unlock(CODE_FULL, FL | {16'h0, UNLOCK_ADDR1});
    #1;
    `CHK("full", 1'b1, erase_full & erase_run & ~ready)
    bus_wr(FL, 16'h00b0);
    tick(2);
    `CHK("no suspend", 1'b0, ready)
    bus_rd(FL, SIZE_HALF, r1);
    bus_rd(FL | 32'h2000, SIZE_HALF, r1);
    `CHK("full flags", 2'b01, {r1[BIT_POLL], r1[BIT_WINDOW]})
    wait_ready(200);
    $display("Test full_erase finished");
    hang = 1'b1;
    delay = 8'd100;
    unlock(CODE_ERASE, FL | {16'h0, UNLOCK_ADDR1});
    unlock(CODE_SECTOR, FL | 32'h2000);
    t0 = $time;
    bus_rd(FL, SIZE_HALF, r1);
    bus_rd(FL, SIZE_HALF, r1);
    `CHK("window flag", 1'b0, r1[BIT_WINDOW])
    `CHK("not running", 1'b0, erase_run | ready)
    bus_wr(FL | 32'h4000, 16'h0030);
    for (int i = 0; i < 2000 && erase_run !== 1'b1; i++)
      tick(1);
    el = int'(($time - t0) / 20);
    `CHK("window", 1'b1, (el >= 1749 && el <= 1752))
    `CHK("sectors", 4'b0110, ptr)
    bus_rd(FL, SIZE_HALF, r1);
    bus_rd(FL, SIZE_HALF, r1);
    `CHK("erase flag", 1'b1, r1[BIT_WINDOW])
    bus_wr(FL | 32'h6000, 16'h00b0);
    tick(2);
    `CHK("suspend", 2'b10, {ready, erase_run})
    bus_rd(FL | 32'h2000, SIZE_HALF, r1);
    bus_rd(FL | 32'h2000, SIZE_HALF, r1);
    bus_rd(FL | 32'h2000, SIZE_HALF, r2);
    `CHK("toggle2", ~r1[BIT_TOGGLE2], r2[BIT_TOGGLE2])
    bus_rd(FL | 32'h6000, SIZE_HALF, r1);
    `CHK("other sector", arr_val(FL | 32'h6000), r1)
    hang = 1'b0;
    prog(FL | 32'h6000, 16'h0080);
    `CHK("susp prog", 2'b10, {prog_start, ready})
    bus_rd(FL | 32'h6000, SIZE_HALF, r1);
    bus_rd(FL | 32'h6000, SIZE_HALF, r1);
    `CHK("susp poll", 2'b01, {r1[BIT_POLL], r1[BIT_WINDOW]})
    wait_ready(200);
    hang = 1'b1;
    bus_wr(FL, 16'h0030);
    tick(2);
    `CHK("resume", 2'b01, {ready, erase_run})
    bus_wr(FL | 32'h6000, 16'h0030);
    tick(2);
    `CHK("late add", 5'b01101, {ptr, erase_run})
    bus_wr(FL, 16'h00f0);
    tick(2);
    `CHK("early reset", 1'b0, ready)
    for (int i = 0; i < 300 && tlim !== 1'b1; i++)
      tick(1);
    bus_rd(FL, SIZE_HALF, r1);
    bus_rd(FL, SIZE_HALF, r1);
    `CHK("limit flag", 1'b1, r1[BIT_TLIMIT] & ~ready)
    bus_wr(FL, 16'h00f0);
    tick(2);
    `CHK("reset cmd", 1'b1, ready)
    bus_rd(FL | 32'h2000, SIZE_HALF, r1);
    `CHK("read state", arr_val(FL | 32'h2000), r1)
    hang = 1'b0;
    $display("Test sector_erase finished");
    close_out();
  end
endmodule
